// [common/csc_pkg.sv]
// constants, types and register map of the charger state control core
// assumes a single 125 MHz clock and a classic wishbone master on the register side
// What this block does
// - usb low-power mode selects 100 mV reference
// - 250 mV only with ac and select high
// - qualified recharge blocks charge termination
// - completed charge clears and stops safety timer
// - done is high/low, fault high/high
// - timer expiry while charging faults, stops supply
// - done returns to charging on recharge
// - recharge active when battery below threshold
// - recharge filtered 25 ms both directions
// - recharge activation resets the state machine
// - termination level, not edge, enters done
// - termination active when sense below threshold
// - termination filtered 25 ms before use
// - tied timer pin disables termination and timer
// - without battery machine may cycle freely
package csc_pkg;

    localparam int CLK_HZ        = 125_000_000;
    localparam int DEGLITCH_MS   = 25;
    localparam int DEGLITCH_CYC  = DEGLITCH_MS * (CLK_HZ / 1000);
    localparam int DG_W          = 22;
    localparam int TERM_REF_LO_MV = 100;
    localparam int TERM_REF_HI_MV = 250;

    localparam int WB_AW = 8;

    localparam logic [WB_AW-1:0] OFS_CTRL      = 8'h00;
    localparam logic [WB_AW-1:0] OFS_STATE     = 8'h04;
    localparam logic [WB_AW-1:0] OFS_TMR_LIMIT = 8'h08;
    localparam logic [WB_AW-1:0] OFS_TMR_COUNT = 8'h0c;
    localparam logic [WB_AW-1:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [WB_AW-1:0] OFS_IRQ_CLR   = 8'h14;
    localparam logic [WB_AW-1:0] OFS_IRQ_EN    = 8'h18;

    localparam logic [31:0] RST_CTRL      = 32'h0000_0001;
    localparam logic [31:0] RST_TMR_LIMIT = 32'h0100_0000;
    localparam logic [2:0]  RST_IRQ_EN    = 3'h0;

    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_RESTART = 1;

    localparam int EV_DONE    = 0;
    localparam int EV_FAULT   = 1;
    localparam int EV_RECHG   = 2;
    localparam int EV_N       = 3;

    // status line codes, first line in bit 1
    localparam logic [1:0] STAT_OFF      = 2'h0;
    localparam logic [1:0] STAT_CHARGING = 2'h1;
    localparam logic [1:0] STAT_DONE     = 2'h2;
    localparam logic [1:0] STAT_FAULT    = 2'h3;

    typedef enum logic [1:0] {CSC_CHARGING, CSC_DONE, CSC_FAULT} csc_state_e;

    typedef struct packed {
        logic timer_tied;
        logic source_select;
        logic ac_present;
        logic term_low;
        logic recharge_low;
    } csc_pins_s;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [WB_AW-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } csc_wb_req_s;

endpackage

// [verilog/csc_core.sv]
// charger state control core: pin synchronisers, deglitch filters, charge state
// machine, safety timer, status lines and a wishbone register slave with interrupt
// assumes all pin inputs are asynchronous levels from comparators and board straps
`timescale 1ns/1ps
`default_nettype none

module csc_core #(
    parameter int DEGLITCH_CYC = csc_pkg::DEGLITCH_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire csc_pkg::csc_pins_s  pins_i,
    input  wire csc_pkg::csc_wb_req_s wb_req_i,
    output logic                     wb_ack_o,
    output logic [31:0]              wb_dat_o,
    output logic                     irq_o,
    output logic                     status_line_first_o,
    output logic                     status_line_second_o,
    output logic                     charge_en_o,
    output logic                     regulator_en_o,
    output logic                     term_ref_high_o
);
    import csc_pkg::*;

    localparam int NPIN = $bits(csc_pins_s);
    localparam logic [DG_W-1:0] DG_LAST = DG_W'(DEGLITCH_CYC - 1);

    // ---------------- synchronisers ----------------
    logic [NPIN-1:0] meta_ff;
    logic [NPIN-1:0] sync_ff;
    csc_pins_s       pin_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pins_i;
            sync_ff <= meta_ff;
        end
    end

    assign pin_s = csc_pins_s'(sync_ff);

    // ---------------- deglitch filters ----------------
    // channel 0 recharge, channel 1 termination
    logic [1:0] raw_s;
    logic [1:0] qual_ff;
    logic [DG_W-1:0] dg_cnt_ff [2];

    assign raw_s = {pin_s.term_low, pin_s.recharge_low};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_dg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    qual_ff[g]   <= 1'b0;
                    dg_cnt_ff[g] <= '0;
                end else if (raw_s[g] == qual_ff[g]) begin
                    dg_cnt_ff[g] <= '0;
                end else if (dg_cnt_ff[g] == DG_LAST) begin
                    qual_ff[g]   <= raw_s[g];
                    dg_cnt_ff[g] <= '0;
                end else begin
                    dg_cnt_ff[g] <= dg_cnt_ff[g] + 1'b1;
                end
            end

            // output level moves only after a full uninterrupted interval
            deglitch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
                qual_ff[g] != $past(qual_ff[g]) |-> $past(dg_cnt_ff[g]) == DG_LAST)
                else $error("deglitch output changed before interval elapsed");
            deglitch_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
                raw_s[g] == qual_ff[g] |=> dg_cnt_ff[g] == '0)
                else $error("deglitch count not restarted");
        end
    endgenerate

    logic rch_q;
    logic term_q;
    logic rch_prev_ff;
    logic rch_rise;

    assign rch_q  = qual_ff[0];
    assign term_q = qual_ff[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rch_prev_ff <= 1'b0;
        end else begin
            rch_prev_ff <= rch_q;
        end
    end

    // resetting on the level would keep restarting the safety timer forever
    // on a deeply discharged cell, so only the activation resets the machine
    assign rch_rise = rch_q & ~rch_prev_ff;

    // ---------------- register file ----------------
    logic [31:0]     ctrl_ff;
    logic [31:0]     tmr_limit_ff;
    logic [EV_N-1:0] irq_stat_ff;
    logic [EV_N-1:0] irq_en_ff;
    logic            ack_ff;
    logic [31:0]     dat_ff;
    logic            wr_go;
    logic            restart_pulse;
    logic            enable;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // a write lands on the edge at which the master sees ack
    assign wr_go = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_ff;
    assign restart_pulse = wr_go && wb_req_i.adr == OFS_CTRL && wb_req_i.sel[0]
                           && wb_req_i.dat[CTRL_RESTART];
    assign enable = ctrl_ff[CTRL_ENABLE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff      <= RST_CTRL;
            tmr_limit_ff <= RST_TMR_LIMIT;
            irq_en_ff    <= RST_IRQ_EN;
        end else if (wr_go) begin
            unique case (wb_req_i.adr)
                OFS_CTRL: begin
                    ctrl_ff <= {31'h0, (wb_req_i.sel[0] ? wb_req_i.dat[CTRL_ENABLE]
                                                        : ctrl_ff[CTRL_ENABLE])};
                end
                OFS_TMR_LIMIT: begin
                    tmr_limit_ff <= merge(tmr_limit_ff, wb_req_i.dat, wb_req_i.sel);
                end
                OFS_IRQ_EN: begin
                    if (wb_req_i.sel[0]) begin
                        irq_en_ff <= wb_req_i.dat[EV_N-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------- charge state machine and safety timer ----------------
    csc_state_e  state_ff;
    csc_state_e  nxt_state;
    logic [31:0] timer_ff;
    logic        timer_off;
    logic        timer_expire;
    logic        term_ok;

    assign timer_off    = pin_s.timer_tied;
    assign timer_expire = ~timer_off && timer_ff >= tmr_limit_ff;
    assign term_ok      = term_q && ~rch_q && ~timer_off;

    always_comb begin
        nxt_state = state_ff;
        if (!enable || rch_rise || restart_pulse) begin
            nxt_state = CSC_CHARGING;
        end else begin
            unique case (state_ff)
                CSC_CHARGING: begin
                    if (term_ok) begin
                        nxt_state = CSC_DONE;
                    end else if (timer_expire) begin
                        nxt_state = CSC_FAULT;
                    end
                end
                CSC_DONE: begin
                    if (rch_q) begin
                        nxt_state = CSC_CHARGING;
                    end
                end
                CSC_FAULT: begin
                    nxt_state = CSC_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= CSC_CHARGING;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_ff <= '0;
        end else if (nxt_state != CSC_CHARGING || state_ff != CSC_CHARGING || timer_off
                     || !enable || rch_rise || restart_pulse) begin
            timer_ff <= '0;
        end else if (!timer_expire) begin
            timer_ff <= timer_ff + 32'h1;
        end
    end

    // ---------------- interrupts ----------------
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;

    assign ev[EV_DONE]  = state_ff == CSC_CHARGING && nxt_state == CSC_DONE;
    assign ev[EV_FAULT] = state_ff == CSC_CHARGING && nxt_state == CSC_FAULT;
    assign ev[EV_RECHG] = rch_rise;
    assign clr = (wr_go && wb_req_i.adr == OFS_IRQ_CLR && wb_req_i.sel[0])
                 ? wb_req_i.dat[EV_N-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= '0;
        end else begin
            // a new event wins over a clear in the same cycle
            irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // ---------------- read data ----------------
    logic [31:0] nxt_dat;

    always_comb begin
        nxt_dat = 32'h0;
        unique case (wb_req_i.adr)
            OFS_CTRL:      nxt_dat = ctrl_ff;
            OFS_STATE:     nxt_dat = {24'h0, timer_off, term_ref_high_o, term_q, rch_q,
                                      2'h0, 2'(state_ff)};
            OFS_TMR_LIMIT: nxt_dat = tmr_limit_ff;
            OFS_TMR_COUNT: nxt_dat = timer_ff;
            OFS_IRQ_STAT:  nxt_dat = {29'h0, irq_stat_ff};
            OFS_IRQ_EN:    nxt_dat = {29'h0, irq_en_ff};
            default:       nxt_dat = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0;
        end else if (wb_req_i.cyc && wb_req_i.stb && !ack_ff) begin
            dat_ff <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ---------------- pin outputs ----------------
    logic [1:0] nxt_stat;

    always_comb begin
        nxt_stat = STAT_OFF;
        if (enable) begin
            unique case (state_ff)
                CSC_CHARGING: nxt_stat = STAT_CHARGING;
                CSC_DONE:     nxt_stat = STAT_DONE;
                CSC_FAULT:    nxt_stat = STAT_FAULT;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_line_first_o  <= 1'b0;
            status_line_second_o <= 1'b0;
        end else begin
            status_line_first_o  <= nxt_stat[1];
            status_line_second_o <= nxt_stat[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_en_o    <= 1'b0;
            regulator_en_o <= 1'b0;
        end else begin
            charge_en_o    <= enable && state_ff == CSC_CHARGING;
            regulator_en_o <= enable && state_ff != CSC_FAULT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_ref_high_o <= 1'b0;
        end else begin
            term_ref_high_o <= pin_s.ac_present & pin_s.source_select;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_done_reached;
        state_ff == CSC_DONE;
    endsequence

    sequence s_done_code;
        status_line_first_o && !status_line_second_o;
    endsequence

    sequence s_fault_code;
        status_line_first_o && status_line_second_o;
    endsequence

    ref_select_a: assert property (
        term_ref_high_o == $past(pin_s.ac_present && pin_s.source_select))
        else $error("termination reference select wrong");

    ref_low_a: assert property (
        !pin_s.ac_present |=> !term_ref_high_o)
        else $error("high reference chosen without ac input");

    term_block_a: assert property (
        state_ff == CSC_CHARGING && rch_q |=> state_ff != CSC_DONE)
        else $error("termination taken while recharge active");

    done_timer_a: assert property (
        s_done_reached |-> timer_ff == 32'h0)
        else $error("safety timer running after completion");

    done_code_a: assert property (
        (enable and s_done_reached) ##1 enable |-> s_done_code)
        else $error("done status code wrong");

    fault_code_a: assert property (
        enable && state_ff == CSC_FAULT ##1 enable |-> s_fault_code)
        else $error("fault status code wrong");

    timer_fault_a: assert property (
        enable && state_ff == CSC_CHARGING && timer_expire && !term_ok && !rch_rise
        && !restart_pulse |=> state_ff == CSC_FAULT ##1 !charge_en_o && !regulator_en_o)
        else $error("expiry did not fault and stop supply");

    recharge_exit_a: assert property (
        (enable and s_done_reached and rch_q) |=> state_ff == CSC_CHARGING)
        else $error("recharge did not leave done");

    recharge_reset_a: assert property (
        rch_rise |=> state_ff == CSC_CHARGING && timer_ff == 32'h0)
        else $error("recharge activation did not reset machine");

    term_level_a: assert property (
        enable && state_ff == CSC_CHARGING && term_ok && !rch_rise && !restart_pulse
        |=> s_done_reached)
        else $error("termination level not acted on");

    tied_pin_a: assert property (
        timer_off && state_ff == CSC_CHARGING |=> state_ff == CSC_CHARGING && timer_ff == 32'h0)
        else $error("tied timer pin did not disable termination and timer");

    bus_ack_a: assert property (
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer timing wrong");

endmodule

`default_nettype wire

// [testbench/csc_supply_model.sv]
// battery and input source model facing the charger core: comparators and board straps
// assumes the bench moves the analog levels just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module csc_supply_model (
    input  wire logic               clk_i,
    input  wire logic [15:0]        vbat_mv_i,
    input  wire logic [15:0]        sense_mv_i,
    input  wire logic               ac_i,
    input  wire logic               sel_i,
    input  wire logic               tied_i,
    input  wire logic               ref_high_i,
    output csc_pkg::csc_pins_s      pins_o
);
    import csc_pkg::*;

    // recharge threshold of 4100 mV
    localparam logic [15:0] RECHG_MV = 16'h1004;

    // comparators follow the core's reference choice, so a wrong choice shows as a wrong stop
    always_ff @(posedge clk_i) begin
        pins_o.recharge_low  <= vbat_mv_i < RECHG_MV;
        pins_o.term_low      <= sense_mv_i < (ref_high_i ? 16'h00fa : 16'h0064);
        pins_o.ac_present    <= ac_i;
        pins_o.source_select <= sel_i;
        pins_o.timer_tied    <= tied_i;
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the charger core with a short deglitch interval
// assumes the supply model in its own file and a classic wishbone master here
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import csc_pkg::*;

    localparam int DG = 8;

    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    csc_wb_req_s   wb_req = '0;
    csc_pins_s     pins;
    logic          wb_ack_o;
    logic [31:0]   wb_dat_o;
    logic          irq_o;
    logic          status_line_first_o;
    logic          status_line_second_o;
    logic          charge_en_o;
    logic          regulator_en_o;
    logic          term_ref_high_o;
    logic [15:0]   vbat_mv = 16'h1068;
    logic [15:0]   sense_mv = 16'h01f4;
    logic          ac = 1'b0;
    logic          sel = 1'b0;
    logic          tied = 1'b0;
    int            n_errors = 0;
    int            samples_checked = 0;

    always #4 clk_i = ~clk_i;

    csc_core #(.DEGLITCH_CYC(DG)) u_dut (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .pins_i               (pins),
        .wb_req_i             (wb_req),
        .wb_ack_o             (wb_ack_o),
        .wb_dat_o             (wb_dat_o),
        .irq_o                (irq_o),
        .status_line_first_o  (status_line_first_o),
        .status_line_second_o (status_line_second_o),
        .charge_en_o          (charge_en_o),
        .regulator_en_o       (regulator_en_o),
        .term_ref_high_o      (term_ref_high_o)
    );

    csc_supply_model u_supply (
        .clk_i      (clk_i),
        .vbat_mv_i  (vbat_mv),
        .sense_mv_i (sense_mv),
        .ac_i       (ac),
        .sel_i      (sel),
        .tied_i     (tied),
        .ref_high_i (term_ref_high_o),
        .pins_o     (pins)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // holds the request until ack is seen at an edge, then releases it
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                            output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, wdat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        // the slave answers in the cycle after it takes the request
        check(32'(n), 32'd2);
        rdat = wb_dat_o;
        wb_req <= '0;
    endtask

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_cycle(1'b1, adr, dat, d);
    endtask

    task automatic wb_rd_chk(input logic [7:0] adr, input logic [31:0] mask,
                             input logic [31:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 32'h0, d);
        check(d & mask, exp);
    endtask

    task automatic set_levels(input logic [15:0] v, input logic [15:0] s);
        @(posedge clk_i);
        vbat_mv  <= v;
        sense_mv <= s;
    endtask

    task automatic chk_stat(input logic [1:0] exp);
        check({30'h0, status_line_first_o, status_line_second_o}, {30'h0, exp});
    endtask

    task automatic s_regs();
        wb_rd_chk(OFS_CTRL, 32'hffff_ffff, RST_CTRL);
        wb_rd_chk(OFS_TMR_LIMIT, 32'hffff_ffff, RST_TMR_LIMIT);
        wb_rd_chk(OFS_IRQ_EN, 32'hffff_ffff, {29'h0, RST_IRQ_EN});
        wb_wr(8'h40, 32'hffff_ffff);
        wb_rd_chk(8'h40, 32'hffff_ffff, 32'h0);
        chk_stat(STAT_CHARGING);
        $display("test registers done");
    endtask

    task automatic s_refs();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            ac  <= i[1];
            sel <= i[0];
            wait_cyc(6);
            check({31'h0, term_ref_high_o}, {31'h0, i == 3});
        end
        @(posedge clk_i);
        sel <= 1'b0;
        $display("test reference done");
    endtask

    task automatic s_term();
        // two short dips that add up past the interval must not count
        set_levels(16'h1068, 16'h0032);
        wait_cyc(5);
        set_levels(16'h1068, 16'h01f4);
        wait_cyc(1);
        set_levels(16'h1068, 16'h0032);
        wait_cyc(5);
        set_levels(16'h1068, 16'h01f4);
        wait_cyc(20);
        chk_stat(STAT_CHARGING);
        wb_wr(OFS_IRQ_EN, 32'h1);
        set_levels(16'h1068, 16'h0032);
        wait_cyc(20);
        chk_stat(STAT_DONE);
        check({31'h0, charge_en_o}, 32'h0);
        wb_rd_chk(OFS_STATE, 32'h3, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        wb_wr(OFS_IRQ_EN, 32'h0);
        wait_cyc(2);
        check({31'h0, irq_o}, 32'h0);
        wb_rd_chk(OFS_IRQ_STAT, 32'h1, 32'h1);
        wb_wr(OFS_IRQ_CLR, 32'h1);
        wb_rd_chk(OFS_IRQ_STAT, 32'h1, 32'h0);
        wb_wr(OFS_TMR_LIMIT, 32'd40);
        wait_cyc(120);
        chk_stat(STAT_DONE);
        wb_rd_chk(OFS_TMR_COUNT, 32'hffff_ffff, 32'h0);
        $display("test termination done");
    endtask

    task automatic s_recharge();
        wb_wr(OFS_TMR_LIMIT, 32'h1000);
        set_levels(16'h0fa0, 16'h0032);
        wait_cyc(4);
        set_levels(16'h1068, 16'h0032);
        wait_cyc(20);
        chk_stat(STAT_DONE);
        set_levels(16'h0fa0, 16'h0032);
        wait_cyc(20);
        chk_stat(STAT_CHARGING);
        wait_cyc(30);
        chk_stat(STAT_CHARGING);
        set_levels(16'h1068, 16'h0032);
        wait_cyc(4);
        chk_stat(STAT_CHARGING);
        wait_cyc(20);
        chk_stat(STAT_DONE);
        $display("test recharge done");
    endtask

    task automatic s_fault();
        wb_wr(OFS_TMR_LIMIT, 32'd40);
        set_levels(16'h0fa0, 16'h01f4);
        wait_cyc(20);
        set_levels(16'h1068, 16'h01f4);
        wait_cyc(100);
        chk_stat(STAT_FAULT);
        check({30'h0, charge_en_o, regulator_en_o}, 32'h0);
        wb_rd_chk(OFS_IRQ_STAT, 32'h2, 32'h2);
        // disabling the core must blank the status lines and the supply
        wb_wr(OFS_CTRL, 32'h0);
        wait_cyc(3);
        chk_stat(STAT_OFF);
        check({30'h0, charge_en_o, regulator_en_o}, 32'h0);
        wb_wr(OFS_CTRL, 32'h3);
        wait_cyc(4);
        chk_stat(STAT_CHARGING);
        $display("test fault done");
    endtask

    task automatic s_tied();
        @(posedge clk_i);
        tied <= 1'b1;
        wait_cyc(6);
        wb_wr(OFS_CTRL, 32'h3);
        set_levels(16'h1068, 16'h0032);
        wait_cyc(100);
        chk_stat(STAT_CHARGING);
        check({31'h0, regulator_en_o}, 32'h1);
        $display("test tied timer pin done");
    endtask

    // whole run is a few hundred cycles, so this span only trips on a hang
    initial begin
        #200000;
        n_errors++;
        summarize();
    end

    initial begin
        wait_cyc(16);
        rst_i <= 1'b0;
        wait_cyc(4);
        s_regs();
        s_refs();
        s_term();
        s_recharge();
        s_fault();
        s_tied();
        summarize();
    end
endmodule
`default_nettype wire
